/* wwdrs_cpu.sv */
// Processor model that kicks the watchdog at a set period
`timescale 1ns/10ps
module wwdrs_cpu (
  input wire mclk,
  input wire [15:0] period,
  output reg watchdog_kick_in
);
  int cnt = 0;
  initial watchdog_kick_in = 1'b1;
  // Low phase of 76 cycles stays above 300ns
  always @(posedge mclk) begin
    cnt <= (cnt + 1 >= period) ? 0 : cnt + 1;
    watchdog_kick_in <= (cnt >= 76);
  end
endmodule // wwdrs_cpu

/* wwdrs_mr_filter.v */
// Glitch filter for the active-low manual reset input
`timescale 1ns/10ps
`include "wwdrs_regs.vh"
module wwdrs_mr_filter (
  input wire mclk,
  input wire rst,
  input wire manual_reset_n,
  output reg mr_low
);
  reg [`WWDRS_FLT_W-1:0] low_cnt;
  // ************************************************************
  // Low must persist past the glitch width before it counts
  // ************************************************************
  always @(posedge mclk) begin
    if (rst) begin
      low_cnt <= 6'h00;
      mr_low <= 1'b0;
    end else if (manual_reset_n) begin
      low_cnt <= 6'h00;
      mr_low <= 1'b0; // see R11
    end else if (low_cnt > `WWDRS_MR_GLITCH_CYC) begin
      mr_low <= 1'b1; // see R11
    end else begin
      low_cnt <= low_cnt + 6'h01;
    end
  end
endmodule // wwdrs_mr_filter

/* wwdrs_props.sv */
// Checker of the windowed watchdog reset supervisor
`timescale 1ns/10ps
module wwdrs_props #(parameter int RESET_HOLD_CYC = 50) (
  input wire mclk,
  input wire rst,
  input wire supply_good,
  input wire manual_reset_n,
  input wire watchdog_kick_in,
  input wire reset_n,
  input wire watchdog_fault_pulse_n,
  input wire fast_fault,
  input wire slow_fault
);
  // Cycles since supply and manual reset both went good
  int up = 0;
  always @(posedge mclk) begin
    up <= (rst || !supply_good || !manual_reset_n) ? 0 : up + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sup_loss_a:
    assert property (!supply_good |-> ##2 !reset_n) else $error("no reset");
  hold_time_a:
    assert property ($rose(reset_n) |-> up >= RESET_HOLD_CYC)
      else $error("reset short");
  flt_off_a:
    assert property (!reset_n ##1 !reset_n |-> watchdog_fault_pulse_n)
      else $error("fault in reset");
  no_wd_rst_a:
    assert property ($fell(watchdog_fault_pulse_n) |-> reset_n [*8])
      else $error("fault reset");
  fast_pair_a:
    assert property (fast_fault |-> $fell(watchdog_fault_pulse_n)
      && !slow_fault) else $error("fast no pulse");
  slow_pair_a:
    assert property (slow_fault |-> $fell(watchdog_fault_pulse_n))
      else $error("slow no pulse");
  pulse_len_a:
    assert property ($fell(watchdog_fault_pulse_n) |->
      !watchdog_fault_pulse_n [*8] ##[1:4] watchdog_fault_pulse_n)
      else $error("pulse length");
  kick_quiet_a:
    assert property (!watchdog_fault_pulse_n |=> !fast_fault && !slow_fault)
      else $error("kick in fault");
  mr_glitch_a:
    assert property (reset_n && $fell(manual_reset_n) ##1 !manual_reset_n
      [*4] ##1 manual_reset_n |-> reset_n [*8]) else $error("glitch reset");
  release_gap_a:
    assert property ($rose(watchdog_fault_pulse_n) |->
      watchdog_fault_pulse_n [*8]) else $error("fault refired");
  cover property (fast_fault);
  cover property (slow_fault);
  cover property ($rose(reset_n));
endmodule // wwdrs_props
bind wwdrs_top wwdrs_props #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) i_wwdrs_props (
  .mclk(mclk), .rst(rst), .supply_good(supply_good),
  .manual_reset_n(manual_reset_n), .watchdog_kick_in(watchdog_kick_in),
  .reset_n(reset_n), .watchdog_fault_pulse_n(watchdog_fault_pulse_n),
  .fast_fault(fast_fault), .slow_fault(slow_fault));

/* wwdrs_regs.vh */
// Constants and timing counts of the windowed watchdog reset supervisor
// Function
// R01: Two kick falling edges closer than the minimum window give a fault pulse.
// R02: No kick falling edge within the maximum window gives a fault pulse.
// R03: Window timer clears on valid kick edge, reset release or fault release.
// R04: Kick transitions are ignored while reset or fault output is asserted.
// R05: First kick edge after reset or fault release never gives a fast fault.
// R06: A fault drives the active-low fault output low for about 1ms.
// R07: Watchdog faults never assert the reset output.
// R08: Processor spaces kick falling edges between minimum and maximum window.
// R09: Reset asserts while supply is bad or manual reset is low.
// R10: Reset holds at least 100ms after supply good and manual reset high.
// R11: Manual reset low glitches of about 100ns are filtered out.
// R12: Manual reset must be held low at least 1us by the other party.
// R13: Manual reset low holds window timer at zero and releases fault output.
// R14: Each kick pulse lasts at least 300ns.
// R15: Fault output pulses only while reset output is deasserted.
// R16: Window, fault pulse and reset hold times are build-time cycle counts.
`ifndef WWDRS_REGS_VH
`define WWDRS_REGS_VH

`define WWDRS_CLK_MHZ 250
// ************************************************************
// Times in their own units
// ************************************************************
`define WWDRS_FAULT_PULSE_US 1000
`define WWDRS_RESET_HOLD_US 100000
`define WWDRS_MR_GLITCH_NS 100
`define WWDRS_MIN_WINDOW_US 1000
`define WWDRS_MAX_WINDOW_US 100000
// ************************************************************
// Derived cycle counts
// ************************************************************
`define WWDRS_FAULT_PULSE_CYC (`WWDRS_FAULT_PULSE_US * `WWDRS_CLK_MHZ)
`define WWDRS_RESET_HOLD_CYC (`WWDRS_RESET_HOLD_US * `WWDRS_CLK_MHZ)
`define WWDRS_MR_GLITCH_CYC ((`WWDRS_MR_GLITCH_NS * `WWDRS_CLK_MHZ + 999) / 1000)
`define WWDRS_MIN_WINDOW_CYC (`WWDRS_MIN_WINDOW_US * `WWDRS_CLK_MHZ)
`define WWDRS_MAX_WINDOW_CYC (`WWDRS_MAX_WINDOW_US * `WWDRS_CLK_MHZ)
`define WWDRS_CNT_W 32
`define WWDRS_FLT_W 6

`endif

/* wwdrs_timer.v */
// Cycle counter that clears, holds at one below its limit and flags expiry
`timescale 1ns/10ps
`include "wwdrs_regs.vh"
module wwdrs_timer (
  input wire mclk,
  input wire rst,
  input wire clear,
  input wire [`WWDRS_CNT_W-1:0] limit,
  output reg [`WWDRS_CNT_W-1:0] count,
  output reg done
);
  always @(posedge mclk) begin
    if (rst || clear) begin
      count <= 32'h00000000;
      done <= 1'b0;
    end else if (count >= limit - 32'h00000001) begin
      done <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
    end
  end
endmodule // wwdrs_timer

/* wwdrs_top.v */
// Windowed watchdog with power-on and manual reset sequencing
`timescale 1ns/10ps
`include "wwdrs_regs.vh"
module wwdrs_top #(
  parameter [31:0] MIN_WINDOW_CYC = `WWDRS_MIN_WINDOW_CYC,
  parameter [31:0] MAX_WINDOW_CYC = `WWDRS_MAX_WINDOW_CYC,
  parameter [31:0] FAULT_PULSE_CYC = `WWDRS_FAULT_PULSE_CYC,
  parameter [31:0] RESET_HOLD_CYC = `WWDRS_RESET_HOLD_CYC
) (
  input wire mclk,
  input wire rst,
  input wire supply_good,
  input wire manual_reset_n,
  input wire watchdog_kick_in,
  output reg reset_n,
  output reg watchdog_fault_pulse_n,
  output reg fast_fault,
  output reg slow_fault
);
  // See R16: all four timings are build-time cycle counts
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ARMED = 3'b010;
  localparam [2:0] ST_FAULT = 3'b100;

  wire mr_low;
  wire hold_clear;
  wire [31:0] hold_count;
  wire hold_done;
  wire [31:0] win_count;
  wire win_done;
  wire [31:0] pulse_count;
  wire pulse_done;
  wire kick_fall;
  wire win_clear;
  reg kick_prev;
  reg [2:0] state;
  reg [2:0] next_state;
  reg first_kick;
  reg reset_prev;
  reg fault_prev;

  // ************************************************************
  // Manual reset filter and reset hold
  // ************************************************************
  wwdrs_mr_filter u_filter (
    .mclk(mclk),
    .rst(rst),
    .manual_reset_n(manual_reset_n),
    .mr_low(mr_low)
  );

  assign hold_clear = mr_low || !supply_good; // see R09
  wwdrs_timer u_hold (
    .mclk(mclk),
    .rst(rst),
    .clear(hold_clear),
    .limit(RESET_HOLD_CYC),
    .count(hold_count),
    .done(hold_done)
  );

  always @(posedge mclk) begin
    if (rst) begin
      reset_n <= 1'b0;
    end else begin
      // Faults play no part here
      reset_n <= hold_done && !hold_clear; // see R07 R09 R10
    end
  end

  // ************************************************************
  // Kick edge detect, window timer and fault pulse timer
  // ************************************************************
  always @(posedge mclk) begin
    if (rst) begin
      kick_prev <= 1'b1;
      reset_prev <= 1'b0;
      fault_prev <= 1'b1;
    end else begin
      kick_prev <= watchdog_kick_in;
      reset_prev <= reset_n;
      fault_prev <= watchdog_fault_pulse_n;
    end
  end

  // Edges count only while both outputs are released
  assign kick_fall = kick_prev && !watchdog_kick_in && reset_n &&
    watchdog_fault_pulse_n && !mr_low; // see R04
  assign win_clear = mr_low || !reset_n || (kick_fall && state == ST_ARMED) ||
    (reset_n && !reset_prev) ||
    (watchdog_fault_pulse_n && !fault_prev); // see R03 R13

  wwdrs_timer u_win (
    .mclk(mclk),
    .rst(rst),
    .clear(win_clear),
    .limit(MAX_WINDOW_CYC),
    .count(win_count),
    .done(win_done)
  );

  wwdrs_timer u_pulse (
    .mclk(mclk),
    .rst(rst),
    .clear(state != ST_FAULT),
    .limit(FAULT_PULSE_CYC),
    .count(pulse_count),
    .done(pulse_done)
  );

  // ************************************************************
  // Watchdog state machine
  // ************************************************************
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (reset_n && !mr_low) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!reset_n || mr_low) begin
          next_state = ST_IDLE;
        end else if (kick_fall && !first_kick &&
            win_count < MIN_WINDOW_CYC) begin
          next_state = ST_FAULT; // see R01 R05
        end else if (win_done && !win_clear) begin
          // A stale expiry must not refire in the cycle the timer clears
          next_state = ST_FAULT; // see R02 R03
        end
      end
      ST_FAULT: begin
        if (!reset_n || mr_low) begin
          next_state = ST_IDLE; // see R13 R15
        end else if (pulse_done) begin
          next_state = ST_ARMED; // see R06
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      state <= ST_IDLE;
      first_kick <= 1'b1;
      watchdog_fault_pulse_n <= 1'b1;
      fast_fault <= 1'b0;
      slow_fault <= 1'b0;
    end else begin
      state <= next_state;
      watchdog_fault_pulse_n <= !(next_state == ST_FAULT); // see R06 R15
      fast_fault <= state == ST_ARMED && next_state == ST_FAULT &&
        kick_fall;
      slow_fault <= state == ST_ARMED && next_state == ST_FAULT &&
        !kick_fall;
      if (next_state != ST_ARMED) begin
        first_kick <= 1'b1; // see R05
      end else if (kick_fall) begin
        first_kick <= 1'b0;
      end
    end
  end
endmodule // wwdrs_top

/* wwdrs_top_test.sv */
// Self-checking bench of the windowed watchdog reset supervisor
`timescale 1ns/10ps
module wwdrs_top_test;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg supply_good = 1'b1;
  reg mr_n = 1'b1;
  reg [15:0] period = 16'hC8;
  wire kick, reset_n, fault_n, fast_fault, slow_fault;
  int n_fail = 0, num_checks = 0, nfast = 0, nslow = 0, k;
  typedef struct { int per; bit fast; bit slow; } wwdrs_row_t;
  wwdrs_row_t rows [5] = '{'{200, 0, 0}, '{104, 0, 0}, '{396, 0, 0},
    '{90, 1, 0}, '{600, 0, 1}};
  wwdrs_top #(.MIN_WINDOW_CYC(100), .MAX_WINDOW_CYC(400),
    .FAULT_PULSE_CYC(10), .RESET_HOLD_CYC(50)) i_wwdrs_top (
    .mclk(mclk), .rst(rst), .supply_good(supply_good),
    .manual_reset_n(mr_n), .watchdog_kick_in(kick), .reset_n(reset_n),
    .watchdog_fault_pulse_n(fault_n), .fast_fault(fast_fault),
    .slow_fault(slow_fault));
  wwdrs_cpu i_wwdrs_cpu (.mclk(mclk), .period(period),
    .watchdog_kick_in(kick));
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) begin
    nfast += (fast_fault === 1'b1);
    nslow += (slow_fault === 1'b1);
  end
  task chk(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts cycles until reset output releases
  task hold_check;
    k = 0;
    while (reset_n !== 1'b1 && k < 400) begin
      @(negedge mclk);
      k++;
    end
    chk(k >= 50 && k < 400, 1);
  endtask
  task tally_and_finish;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (5) @(posedge mclk);
    chk(reset_n, 0);
    rst <= 1'b0;
    hold_check;
    foreach (rows[i]) begin
      @(posedge mclk) period <= rows[i].per[15:0];
      repeat (1000) @(posedge mclk);
      nfast = 0;
      nslow = 0;
      repeat (1600) @(negedge mclk);
      chk(nfast > 0, rows[i].fast);
      chk(nslow > 0, rows[i].slow);
      chk(nfast + nslow < 12, 1);
      chk(reset_n, 1);
    end
    @(posedge mclk) period <= 16'hC8;
    repeat (1000) @(posedge mclk);
    supply_good <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(reset_n, 0);
    chk(fault_n, 1);
    @(posedge mclk) supply_good <= 1'b1;
    hold_check;
    repeat (500) @(posedge mclk);
    mr_n <= 1'b0;
    repeat (5) @(posedge mclk);
    mr_n <= 1'b1;
    repeat (40) @(negedge mclk);
    chk(reset_n, 1);
    @(posedge mclk) mr_n <= 1'b0;
    repeat (260) @(negedge mclk);
    chk(reset_n, 0);
    chk(fault_n, 1);
    @(posedge mclk) mr_n <= 1'b1;
    hold_check;
    tally_and_finish;
  end
endmodule // wwdrs_top_test
